// [hw/mfs_pkg.sv]
package mfs_pkg;
  // ==========================================================
  // register map: one aligned 32-bit word per source register
  localparam int          MFS_NUM_REGS   = 8;
  localparam int          MFS_NUM_SLOTS  = 4;
  localparam int          MFS_ADDR_W     = 8;
  localparam logic [7:0]  MFS_OFF_SUB2   = 8'h00;
  localparam logic [7:0]  MFS_OFF_SUB3   = 8'h04;
  localparam logic [7:0]  MFS_OFF_SUB4   = 8'h08;
  localparam logic [7:0]  MFS_OFF_SUB5   = 8'h0c;
  localparam logic [7:0]  MFS_OFF_SUB6   = 8'h10;
  localparam logic [7:0]  MFS_OFF_SUB7   = 8'h14;
  localparam logic [7:0]  MFS_OFF_SUB8   = 8'h18;
  localparam logic [7:0]  MFS_OFF_SUB9   = 8'h1c;
  localparam int          MFS_IDX_SUB2   = 0;
  localparam int          MFS_IDX_SUB3   = 1;
  localparam int          MFS_IDX_SUB4   = 2;
  localparam int          MFS_IDX_SUB5   = 3;
  localparam int          MFS_IDX_SUB6   = 4;
  localparam int          MFS_IDX_SUB7   = 5;
  localparam int          MFS_IDX_SUB8   = 6;
  localparam int          MFS_IDX_SUB9   = 7;

  // ==========================================================
  // field layout: flags in the upper nibble, enables in the lower
  localparam int          MFS_FLAG_LSB   = 4;
  localparam int          MFS_EN_LSB     = 0;
  localparam logic [3:0]  MFS_MASK_FULL  = 4'hf;
  localparam logic [3:0]  MFS_MASK_TWO   = 4'h3;
  localparam logic [3:0]  MFS_MASK_THREE = 4'h7;
  localparam logic [3:0]  MFS_RST_NIB    = 4'h0;
  localparam logic [31:0] MFS_RDATA_ZERO = 32'h0000_0000;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0][3:0] flag;
    logic [7:0][3:0] en;
    logic [7:0]      grp;
    logic            rdy;
    logic            err;
    logic [31:0]     rdata;
  } mfs_state_t;
endpackage

// [hw/mfs_source_regs.sv]
// Notes on behaviour
// - second periodic timer source register: A/P flags bits 5/4, enables 1/0.
// - unimplemented bits 7~6 and 3~2 of two-pair registers always read zero.
// - fourth register: standard timer A/P bits 7/6, periodic timer A/P 5/4.
// - two-UART variant: UART flags at bits 5/4, enables 1/0, rest zero.
// - three-UART variant adds third UART flag bit 6, enable bit 2.
// - sixth register: comparator a flag bit 6/enable 2, timer pair 5/4.
// - seventh register: comparator b flag bit 6/enable 2, timer pair 5/4.
// - eighth register: time base a flag bit 6/enable 2, timer pair 5/4.
// - ninth register: time base b flag bit 6/enable 2, timer pair 5/4.
// - flags read one while pending; software reads and writes them all.
// - enable bits enable when one, disable when zero; fully read/write.
// - grouped flag sets when an enabled source in its register raises a flag.
// - servicing clears only the grouped flag; source flags stay set.
//
// Added by the designer: the register offsets and the APB register port.
module mfs_source_regs
  import mfs_pkg::*;
#(
  parameter bit THREE_UART = 1'b1
) (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // apb slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [mfs_pkg::MFS_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                   PWDATA,
  input  wire logic [3:0]                    PSTRB,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // peripheral request pulses, register index * 4 + slot
  input  wire logic [31:0]                   SRC_REQ,
  // service acknowledges from and grouped flags toward the top-level controller
  input  wire logic [7:0]                    SERVICE_ACK,
  output logic      [7:0]                    GROUPED_REQUEST_FLAG
);
  import mfs_pkg::*;

  // ==========================================================
  // helpers
  // implemented slots of each register; slot k is flag 4+k, enable k
  function automatic logic [3:0] impl_mask(input int idx);
    logic [3:0] m;
    m = MFS_MASK_THREE;
    if (idx == MFS_IDX_SUB2) begin
      m = MFS_MASK_TWO;
    end else if (idx == MFS_IDX_SUB3 || idx == MFS_IDX_SUB4) begin
      m = MFS_MASK_FULL;
    end else if (idx == MFS_IDX_SUB5) begin
      m = THREE_UART ? MFS_MASK_THREE : MFS_MASK_TWO;
    end
    return m;
  endfunction

  // address decode: returns hit and register index
  function automatic logic [3:0] addr_decode(input logic [MFS_ADDR_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == MFS_OFF_SUB2) begin
      r = {1'b1, 3'(MFS_IDX_SUB2)};
    end else if (a == MFS_OFF_SUB3) begin
      r = {1'b1, 3'(MFS_IDX_SUB3)};
    end else if (a == MFS_OFF_SUB4) begin
      r = {1'b1, 3'(MFS_IDX_SUB4)};
    end else if (a == MFS_OFF_SUB5) begin
      r = {1'b1, 3'(MFS_IDX_SUB5)};
    end else if (a == MFS_OFF_SUB6) begin
      r = {1'b1, 3'(MFS_IDX_SUB6)};
    end else if (a == MFS_OFF_SUB7) begin
      r = {1'b1, 3'(MFS_IDX_SUB7)};
    end else if (a == MFS_OFF_SUB8) begin
      r = {1'b1, 3'(MFS_IDX_SUB8)};
    end else if (a == MFS_OFF_SUB9) begin
      r = {1'b1, 3'(MFS_IDX_SUB9)};
    end
    return r;
  endfunction

  // ==========================================================
  // state
  mfs_state_t s_r;
  mfs_state_t s_nxt;
  logic [3:0] dec;
  logic       hit;
  logic [2:0] idx;
  logic       acc_first;
  logic       wr_en;

  // access decode; one wait state so every answer is registered
  assign dec       = addr_decode(PADDR);
  assign hit       = dec[3];
  assign idx       = dec[2:0];
  assign acc_first = PSEL && PENABLE && !s_r.rdy;
  // write lands only at the edge where pready is sampled high
  assign wr_en     = PSEL && PENABLE && s_r.rdy && PWRITE && hit && PSTRB[0];

  // ==========================================================
  // next state
  always_comb begin
    logic [3:0] m;
    logic       nf;
    logic       ne;
    logic       raise;
    m     = MFS_RST_NIB;
    nf    = 1'b0;
    ne    = 1'b0;
    raise = 1'b0;
    s_nxt = s_r;
    // bus answer
    s_nxt.rdy = acc_first;
    s_nxt.err = acc_first && !hit;
    if (acc_first) begin
      if (hit && !PWRITE) begin
        m = impl_mask(int'(idx));
        // masked so unimplemented bits read zero
        s_nxt.rdata = {24'h00_0000, s_r.flag[idx] & m, s_r.en[idx] & m};
      end else begin
        s_nxt.rdata = MFS_RDATA_ZERO;
      end
    end
    // flags, enables and grouped flags
    for (int i = 0; i < MFS_NUM_REGS; i++) begin
      m     = impl_mask(i);
      raise = 1'b0;
      for (int k = 0; k < MFS_NUM_SLOTS; k++) begin
        nf = s_r.flag[i][k];
        ne = s_r.en[i][k];
        if (wr_en && int'(idx) == i) begin
          nf = PWDATA[MFS_FLAG_LSB + k] & m[k];
          ne = PWDATA[MFS_EN_LSB + k] & m[k];
        end
        // peripheral pulse beats a simultaneous write of zero
        if (SRC_REQ[i * MFS_NUM_SLOTS + k] && m[k]) begin
          nf = 1'b1;
        end
        if (nf && !s_r.flag[i][k] && ne) begin
          raise = 1'b1;
        end
        s_nxt.flag[i][k] = nf;
        s_nxt.en[i][k]   = ne;
      end
      // service clears only the grouped flag; a new raise wins
      s_nxt.grp[i] = (s_r.grp[i] && !SERVICE_ACK[i]) || raise;
    end
  end

  // register the state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign PRDATA               = s_r.rdata;
  assign PREADY               = s_r.rdy;
  assign PSLVERR              = s_r.err;
  assign GROUPED_REQUEST_FLAG = s_r.grp;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  timer_c_unused_a: assert property (
    s_r.flag[MFS_IDX_SUB2][3:2] == 2'b00 && s_r.en[MFS_IDX_SUB2][3:2] == 2'b00)
    else $error("unused bits of timer c register set");

  unimpl_read_a: assert property (
    acc_first && !PWRITE && hit && idx == 3'(MFS_IDX_SUB6)
    |=> PREADY && PRDATA[7] == 1'b0 && PRDATA[3] == 1'b0 && PRDATA[31:8] == 24'h00_0000)
    else $error("unimplemented bits read nonzero");

  serial_flag_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB3 * 4 + 3] |=> s_r.flag[MFS_IDX_SUB3][3])
    else $error("serial interface flag not set");

  std_timer_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB4 * 4 + 2] |=> s_r.flag[MFS_IDX_SUB4][2])
    else $error("standard timer p flag not set");

  uart_variant_a: assert property (
    SRC_REQ[MFS_IDX_SUB5 * 4 + 2] |=> s_r.flag[MFS_IDX_SUB5][2] == THREE_UART)
    else $error("third uart flag does not follow the variant");

  comparator_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB6 * 4 + 2] ##1 !wr_en |=> s_r.flag[MFS_IDX_SUB6][2])
    else $error("comparator flag lost without a write");

  group_raise_a: assert property (
    !s_r.flag[MFS_IDX_SUB7][0] && s_r.en[MFS_IDX_SUB7][0] && !wr_en
    && SRC_REQ[MFS_IDX_SUB7 * 4] |=> GROUPED_REQUEST_FLAG[MFS_IDX_SUB7])
    else $error("grouped flag not raised");

  service_keep_a: assert property (
    SERVICE_ACK[MFS_IDX_SUB8] && !wr_en |=> $stable(s_r.flag[MFS_IDX_SUB8])
    || $past(|SRC_REQ[31:24]))
    else $error("service cleared a source flag");

  set_beats_write_a: assert property (
    wr_en && idx == 3'(MFS_IDX_SUB9) && SRC_REQ[MFS_IDX_SUB9 * 4]
    |=> s_r.flag[MFS_IDX_SUB9][0])
    else $error("write of zero beat a request pulse");

  enable_write_a: assert property (
    wr_en && idx == 3'(MFS_IDX_SUB3) |=> s_r.en[MFS_IDX_SUB3] == $past(PWDATA[3:0]))
    else $error("enable write did not land");

  apb_wait_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");

  // ==========================================================
  // register layout: implemented slots and read-back masks
  timer_c_read_a: assert property (
    acc_first && !PWRITE && hit && idx == 3'(MFS_IDX_SUB2)
    |=> PRDATA[7:6] == 2'b00 && PRDATA[3:2] == 2'b00)
    else $error("timer c register read shows unused bits");

  timer_c_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB2 * MFS_NUM_SLOTS + 1] |=> s_r.flag[MFS_IDX_SUB2][1])
    else $error("timer c match a flag not set");

  uart_two_unused_a: assert property (
    s_r.flag[MFS_IDX_SUB5][3] == 1'b0 && s_r.en[MFS_IDX_SUB5][3] == 1'b0)
    else $error("unused uart register bit set");

  err_read_zero_a: assert property (
    acc_first && !hit |=> PSLVERR && PRDATA == MFS_RDATA_ZERO)
    else $error("refused access returned data");

  serial_all_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB3 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS] != 4'h0
    |=> (s_r.flag[MFS_IDX_SUB3] & $past(SRC_REQ[MFS_IDX_SUB3 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS]))
    == $past(SRC_REQ[MFS_IDX_SUB3 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS]))
    else $error("serial register flag not set");

  fourth_all_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB4 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS] != 4'h0
    |=> (s_r.flag[MFS_IDX_SUB4] & $past(SRC_REQ[MFS_IDX_SUB4 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS]))
    == $past(SRC_REQ[MFS_IDX_SUB4 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS]))
    else $error("fourth register flag not set");

  uart_a_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB5 * MFS_NUM_SLOTS] |=> s_r.flag[MFS_IDX_SUB5][0])
    else $error("uart a flag not set");

  uart_b_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB5 * MFS_NUM_SLOTS + 1] |=> s_r.flag[MFS_IDX_SUB5][1])
    else $error("uart b flag not set");

  uart_c_read_a: assert property (
    acc_first && !PWRITE && hit && idx == 3'(MFS_IDX_SUB5)
    |=> PRDATA[7] == 1'b0 && PRDATA[3] == 1'b0)
    else $error("uart register unused bits read nonzero");

  timer_e_unused_a: assert property (
    s_r.flag[MFS_IDX_SUB6][3] == 1'b0 && s_r.en[MFS_IDX_SUB6][3] == 1'b0)
    else $error("sixth register unused bit set");

  timer_e_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB6 * MFS_NUM_SLOTS] |=> s_r.flag[MFS_IDX_SUB6][0])
    else $error("timer e match p flag not set");

  comparator_b_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB7 * MFS_NUM_SLOTS + 2] |=> s_r.flag[MFS_IDX_SUB7][2])
    else $error("comparator b flag not set");

  timer_f_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB7 * MFS_NUM_SLOTS + 1] |=> s_r.flag[MFS_IDX_SUB7][1])
    else $error("timer f match a flag not set");

  time_base_a_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB8 * MFS_NUM_SLOTS + 2] |=> s_r.flag[MFS_IDX_SUB8][2])
    else $error("time base a flag not set");

  timer_g_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB8 * MFS_NUM_SLOTS] |=> s_r.flag[MFS_IDX_SUB8][0])
    else $error("timer g match p flag not set");

  time_base_b_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB9 * MFS_NUM_SLOTS + 2] |=> s_r.flag[MFS_IDX_SUB9][2])
    else $error("time base b flag not set");

  timer_h_set_a: assert property (
    SRC_REQ[MFS_IDX_SUB9 * MFS_NUM_SLOTS + 1] |=> s_r.flag[MFS_IDX_SUB9][1])
    else $error("timer h match a flag not set");

  // ==========================================================
  // software access: writes land once, everything else holds
  flag_write_a: assert property (
    wr_en && idx == 3'(MFS_IDX_SUB4) && SRC_REQ[MFS_IDX_SUB4 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS] == 4'h0
    |=> s_r.flag[MFS_IDX_SUB4] == $past(PWDATA[MFS_FLAG_LSB +: MFS_NUM_SLOTS]))
    else $error("flag write did not land");

  flag_hold_a: assert property (
    !wr_en && SRC_REQ == '0 |=> $stable(s_r.flag))
    else $error("flag changed without cause");

  rdata_hold_a: assert property (
    !acc_first |=> $stable(PRDATA))
    else $error("read data changed between answers");

  ready_pulse_a: assert property (
    PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");

  enable_hold_a: assert property (
    !wr_en |=> $stable(s_r.en))
    else $error("enable changed without a write");

  enable_mask_a: assert property (
    wr_en && idx == 3'(MFS_IDX_SUB6)
    |=> s_r.en[MFS_IDX_SUB6] == ($past(PWDATA[MFS_EN_LSB +: MFS_NUM_SLOTS]) & MFS_MASK_THREE))
    else $error("sixth register enable write wrong");

  // ==========================================================
  // grouped flags and reset
  group_quiet_a: assert property (
    !s_r.grp[MFS_IDX_SUB4] && !wr_en && SRC_REQ[MFS_IDX_SUB4 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS] == 4'h0
    |=> !s_r.grp[MFS_IDX_SUB4])
    else $error("grouped flag rose without a source");

  raise_beats_ack_a: assert property (
    SERVICE_ACK[MFS_IDX_SUB5] && SRC_REQ[MFS_IDX_SUB5 * MFS_NUM_SLOTS] && !wr_en
    && s_r.en[MFS_IDX_SUB5][0] && !s_r.flag[MFS_IDX_SUB5][0]
    |=> s_r.grp[MFS_IDX_SUB5])
    else $error("service beat a new raise");

  group_hold_a: assert property (
    s_r.grp[MFS_IDX_SUB2] && !SERVICE_ACK[MFS_IDX_SUB2] |=> s_r.grp[MFS_IDX_SUB2])
    else $error("grouped flag cleared without service");

  group_clear_a: assert property (
    SERVICE_ACK[MFS_IDX_SUB3] && !wr_en && SRC_REQ[MFS_IDX_SUB3 * MFS_NUM_SLOTS +: MFS_NUM_SLOTS] == 4'h0
    |=> !s_r.grp[MFS_IDX_SUB3])
    else $error("service did not clear grouped flag");

  reset_clear_a: assert property (
    $fell(RST) |-> s_r.flag == '0 && s_r.en == '0 && s_r.grp == '0)
    else $error("state not clear after reset");
endmodule

// [testbench/mfs_periph_model.sv]
// ==========================================================
// peripheral side: request pulses and service acknowledges
module mfs_periph_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // commands from the bench
  input  wire logic        req_go,
  input  wire logic [4:0]  req_bit,
  input  wire logic        ack_go,
  input  wire logic [2:0]  ack_grp,
  // toward the block
  output logic      [31:0] src_req,
  output logic      [7:0]  service_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle pulses only, so a request never reads as a level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_req     <= 32'h0;
      service_ack <= 8'h0;
    end else begin
      src_req     <= req_go ? (32'h1 << req_bit) : 32'h0;
      service_ack <= ack_go ? (8'h1 << ack_grp) : 8'h0;
    end
  end
endmodule

// [testbench/tb.sv]
// ==========================================================
// self-checking bench for the source registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rq = 0, ak = 0;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0, prd, sreq, rnd;
  logic [4:0] rb = 5'h0;
  logic [2:0] ag = 3'h0;
  logic [7:0] sack, grp, mk [8];
  logic pready, perr;
  logic [33:0] q [$];
  int mismatches = 0, check_count = 0;
  always #4 clk = ~clk;
  mfs_periph_model PM (.clk(clk), .rst(rst), .req_go(rq), .req_bit(rb), .ack_go(ak),
    .ack_grp(ag), .src_req(sreq), .service_ack(sack));
  mfs_source_regs DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(pready),
    .PSLVERR(perr), .SRC_REQ(sreq), .SERVICE_ACK(sack), .GROUPED_REQUEST_FLAG(grp));
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_grp(input int i, input logic x);
    cmp({31'h0, grp[i]}, {31'h0, x});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // e = {is_read, expected error, expected data}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    q.push_back(e);
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      give_verdict();
    end
    psel <= 0; pen <= 0;
  endtask
  // monitor: each answer takes the oldest note off the queue
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) cmp(32'h1, 32'h0);
      else begin
        automatic logic [33:0] e = q.pop_front();
        cmp({31'h0, perr}, {31'h0, e[32]});
        if (e[33]) cmp(prd, e[31:0]);
      end
    end
  end
  task automatic pulse(input logic src, input int k);
    @(posedge clk);
    if (src) begin rq <= 1; rb <= 5'(k); end else begin ak <= 1; ag <= 3'(k); end
    @(posedge clk);
    rq <= 0; ak <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    mk = '{8'h33, 8'hff, 8'hff, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77};
    rnd = $urandom(32'h1a18);
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 8; i++) begin
      apb(0, 8'(i*4), 0, {2'b10, 32'h0});
      apb(1, 8'(i*4), 32'hff, 34'h0);
      apb(0, 8'(i*4), 0, {2'b10, 24'h0, mk[i]});
      rnd = $urandom;
      apb(1, 8'(i*4), rnd, 34'h0);
      apb(0, 8'(i*4), 0, {2'b10, 24'h0, rnd[7:0] & mk[i]});
    end
    apb(0, 8'h20, 0, {2'b11, 32'h0}); // unmapped word
    apb(0, 8'h02, 0, {2'b11, 32'h0}); // unaligned
    for (int i = 0; i < 8; i++) begin
      apb(1, 8'(i*4), 32'h0f, 34'h0);
      pulse(0, i);
      cmp_grp(i, 1'b0);
      pulse(1, i*4);
      cmp_grp(i, 1'b1);
      apb(0, 8'(i*4), 0, {2'b10, 24'h0, 8'h1f & mk[i]});
      pulse(0, i);
      cmp_grp(i, 1'b0);
      apb(0, 8'(i*4), 0, {2'b10, 24'h0, 8'h1f & mk[i]});
      apb(1, 8'(i*4), 32'h0, 34'h0);
      apb(0, 8'(i*4), 0, {2'b10, 32'h0});
    end
    // every request line once; only implemented flags may show
    for (int b = 0; b < 32; b++) pulse(1, b);
    for (int i = 0; i < 8; i++) begin
      apb(0, 8'(i*4), 0, {2'b10, 24'h0, mk[i] & 8'hf0});
    end
    // request pulse meets a write of zero at the same edge
    apb(1, 8'h1c, 32'h0, 34'h0);
    fork
      apb(1, 8'h1c, 32'h0, 34'h0);
      begin @(posedge clk); pulse(1, 28); end
    join
    apb(0, 8'h1c, 0, {2'b10, 24'h0, 8'h10});
    @(posedge clk);
    give_verdict();
  end
endmodule
